// File: hdl/mhp_parser.sv
// Purpose: MAC header parser with input FIFO and AHB-Lite control registers
// Assumes: Octet stream starts each frame with the length octet flagged by sof
// Notes:   Results are held until res_ready; the FIFO then back-pressures the source
// Operation
// [R1] Destination mode from control bits 11:10
// [R2] Source mode from bits 15:14, same code
// [R3] Modes: none, reserved, short, extended
// [R4] Destination PAN first, then destination address
// [R5] Version from bits 13:12, 2/3 reserved
// [R6] Version policy decides acknowledgement
// [R7] Selected control bits feed address filter
// [R8] Sequence number copied into acknowledgement
// [R9] Destination field precedes source field
// [R10] Compression drops source PAN when both present
// [R11] Security header only when bit 3 set
// [R12] Security and version combination classified
// [R13] No addresses valid only for ACK
// [R14] Last two octets are the footer
// [R15] Control field from first two octets
// [R16] Frame type bits 2:0, types 0-3 pass
// [R17] Bit 6 is PAN compression flag
// [R18] Offsets from modes, LSB octet first
//
// The register addresses and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps

// ****************************************
// Octet FIFO
// ****************************************
module mhp_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic                rdy;
  } mhp_fifo_st_t;
  localparam mhp_fifo_st_t FIFO_RST = '{rdy: 1'b1, default: '0};

  mhp_fifo_st_t st_reg;
  mhp_fifo_st_t st_next;
  logic         push;
  logic         pop;

  assign out_valid = (st_reg.cnt != '0);
  assign out_data  = st_reg.mem[st_reg.rp];
  assign in_ready  = st_reg.rdy;
  assign push      = in_valid && st_reg.rdy;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wp] = in_data;
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = st_reg.rp + 1'b1;
    end
    st_next.cnt = st_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    // Ready registered so the source sees a flop, not a count compare
    st_next.rdy = (st_next.cnt != (AW+1)'(D));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= FIFO_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  a_fifo_bound: assert property (@(posedge clk) disable iff (rst)
    st_reg.cnt <= (AW+1)'(D)) else $error("fifo count beyond depth");
  a_fifo_count: assert property (@(posedge clk) disable iff (rst)
    push && !pop |=> st_reg.cnt == $past(st_reg.cnt) + 1'b1) else $error("fifo count stuck");
endmodule

// ****************************************
// Header parser top
// ****************************************
module mhp_parser (
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic           in_valid,
  input  wire logic           in_sof,
  input  wire logic [7:0]     in_octet,
  output logic                in_ready,
  output mhp_pkg::mhp_hdr_t     hdr,
  output mhp_pkg::mhp_verdict_t verdict,
  output logic                hdr_valid,
  input  wire logic           res_ready,
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic                hreadyout,
  output logic                hresp,
  output logic [31:0]         hrdata
);
  typedef enum logic [3:0] {
    P_IDLE, P_FCF0, P_FCF1, P_SEQ, P_DPAN, P_DADR, P_SPAN, P_SADR, P_AUX, P_BODY, P_FCS
  } mhp_pst_t;

  typedef struct packed {
    mhp_pst_t              ps;
    logic [6:0]            rem;
    logic [3:0]            cnt;
    mhp_pkg::mhp_hdr_t     hdr;
    logic                  hv;
    logic                  dn;
    mhp_pkg::mhp_verdict_t vd;
    logic [3:0]            ctrl;
    logic [15:0]           frames;
    logic [31:0]           hrdata;
    logic                  hwr;
    logic [7:0]            waddr;
    logic                  hrdy;
    logic                  hresp;
  } mhp_top_st_t;
  localparam mhp_top_st_t TOP_RST = '{ps: P_IDLE, ctrl: mhp_pkg::CTRL_RESET, hrdy: 1'b1,
                                      default: '0};

  mhp_top_st_t        st_reg;
  mhp_top_st_t        st_next;
  mhp_pkg::mhp_word_t fifo_word;
  mhp_pkg::mhp_word_t fifo_in;
  logic               fifo_valid;
  logic               pop;
  logic               stall;

  // ****************************************
  // Decode helpers
  // ****************************************
  // Slot order of the header: position in list, used to find the next present field
  function automatic int unsigned slot_of(input mhp_pst_t p);
    unique case (p)
      P_FCF0:  slot_of = 0;
      P_FCF1:  slot_of = 1;
      P_SEQ:   slot_of = 2;
      P_DPAN:  slot_of = 3;
      P_DADR:  slot_of = 4;
      P_SPAN:  slot_of = 5;
      P_SADR:  slot_of = 6;
      P_AUX:   slot_of = 7;
      default: slot_of = 8;
    endcase
  endfunction

  function automatic mhp_pst_t state_of(input int unsigned i);
    unique case (i)
      1:       state_of = P_FCF1;
      2:       state_of = P_SEQ;
      3:       state_of = P_DPAN;
      4:       state_of = P_DADR;
      5:       state_of = P_SPAN;
      6:       state_of = P_SADR;
      7:       state_of = P_AUX;
      default: state_of = P_BODY;
    endcase
  endfunction

  // [R3] address length per mode
  function automatic logic [3:0] addr_len(input logic [1:0] m);
    addr_len = (m == mhp_pkg::AM_EXT) ? mhp_pkg::LEN_EXT : mhp_pkg::LEN_SHORT;
  endfunction

  function automatic logic [3:0] aux_len_of(input logic [1:0] km);
    unique case (km)
      2'h0: aux_len_of = mhp_pkg::AUX_LEN_KM0;
      2'h1: aux_len_of = mhp_pkg::AUX_LEN_KM1;
      2'h2: aux_len_of = mhp_pkg::AUX_LEN_KM2;
      2'h3: aux_len_of = mhp_pkg::AUX_LEN_KM3;
    endcase
  endfunction

  function automatic logic [7:0] present(input mhp_pkg::mhp_hdr_t h);
    logic dp;
    logic sp;
    // [R3] only short and extended modes carry a PAN and an address
    dp = h.dmode[1];
    sp = h.smode[1];
    present[2:0] = 3'h7;
    // [R4] destination PAN then address
    present[3] = dp;
    present[4] = dp;
    // [R9] [R10] source after destination, PAN dropped when compressed and destination present
    present[5] = sp && !(dp && h.pan_comp);
    present[6] = sp;
    // [R11] security header only when enabled
    present[7] = h.sec;
  endfunction

  function automatic mhp_pst_t next_field(input mhp_pst_t p, input logic [7:0] pres);
    next_field = P_BODY;
    for (int i = 7; i >= 1; i--) begin
      if (i > slot_of(p) && pres[i]) begin
        next_field = state_of(i);
      end
    end
  endfunction

  function automatic mhp_pkg::mhp_verdict_t judge(input mhp_pkg::mhp_hdr_t h,
                                                input logic [3:0] c);
    logic both0;
    logic modes_res;
    logic addr_ok;
    logic ver_ok;
    logic nonstd;
    nonstd = c[mhp_pkg::CTRL_NONSTD_BIT];
    both0 = (h.dmode == mhp_pkg::AM_NONE) && (h.smode == mhp_pkg::AM_NONE);
    modes_res = (h.dmode == mhp_pkg::AM_RES) || (h.smode == mhp_pkg::AM_RES);
    // [R13] empty addressing only for ACK unless non-standard allowed
    addr_ok = (!both0 || h.ftype == mhp_pkg::FT_ACK || nonstd) && (!modes_res || nonstd);
    // [R5] [R12] version and security classes
    judge.ver_reserved = h.ver[1];
    judge.compat   = !h.sec && (h.ver == mhp_pkg::FV_2003);
    judge.sec_2003 = h.sec && (h.ver == mhp_pkg::FV_2003);
    judge.sec_2006 = h.sec && (h.ver == mhp_pkg::FV_2006);
    // [R16] type 0 to 3 pass
    judge.filter_pass = (h.ftype <= mhp_pkg::FT_CMD) && addr_ok && !h.truncated;
    // [R6] policy code is the highest version acknowledged, so 3 takes reserved ones too
    ver_ok = (h.ver <= c[mhp_pkg::CTRL_POL_LSB +: 2]);
    judge.ack_ok = c[mhp_pkg::CTRL_AACK_BIT] && judge.filter_pass && h.ack_req && ver_ok &&
                   (h.ftype != mhp_pkg::FT_ACK) && (h.ftype != mhp_pkg::FT_BEACON) &&
                   (!judge.sec_2003 || nonstd);
    // [R7] [R17] filter bits only in auto-ack receive mode
    judge.filter_bits = c[mhp_pkg::CTRL_AACK_BIT] ? (h.fcf & mhp_pkg::FILTER_MASK) : '0;
    // [R8] sequence number for the acknowledgement
    judge.ack_seq = h.seq;
  endfunction

  // ****************************************
  // Input FIFO
  // ****************************************
  assign fifo_in = '{sof: in_sof, octet: in_octet};

  mhp_fifo #(.W(mhp_pkg::FIFO_W), .D(mhp_pkg::FIFO_D)) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (in_valid),
    .in_data   (fifo_in),
    .in_ready  (in_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_word),
    .out_ready (!stall)
  );

  // Holding an unread result stops the parser; the FIFO then fills and stalls the source
  assign stall = st_reg.hv && !res_ready;
  assign pop   = fifo_valid && !stall;

  // ****************************************
  // Parser and register file
  // ****************************************
  always_comb begin
    logic [7:0]  d;
    logic [6:0]  rem_n;
    logic [3:0]  flen;
    logic [5:0]  bi;
    logic        fend;
    logic        ap;
    logic [3:0]  ctrl_fw;
    mhp_pst_t    nf;
    d = fifo_word.octet;
    rem_n = st_reg.rem - 7'h01;
    bi = {st_reg.cnt[2:0], 3'h0};
    flen = mhp_pkg::LEN_ONE;
    fend = 1'b0;
    nf = P_BODY;
    ap = 1'b0;
    ctrl_fw = st_reg.ctrl;
    st_next = st_reg;
    st_next.dn = 1'b0;
    if (st_reg.hv && res_ready) begin
      st_next.hv = 1'b0;
    end
    if (pop && fifo_word.sof) begin
      // A new length octet aborts whatever frame was in progress
      st_next.hdr = '0;
      st_next.hdr.length = d[6:0];
      st_next.rem = d[6:0];
      st_next.cnt = '0;
      st_next.ps = (d[6:0] == '0) ? P_IDLE : P_FCF0;
    end else if (pop && st_reg.ps != P_IDLE) begin
      st_next.rem = rem_n;
      st_next.cnt = st_reg.cnt + 4'h1;
      // [R18] fields land LSB octet first at their offset
      unique case (st_reg.ps)
        // [R15] control field from first two octets
        P_FCF0: st_next.hdr.fcf[7:0] = d;
        P_FCF1: begin
          st_next.hdr.fcf[15:8] = d;
          st_next.hdr.ftype    = st_reg.hdr.fcf[mhp_pkg::FCF_TYPE_LSB +: 3];
          st_next.hdr.sec      = st_reg.hdr.fcf[mhp_pkg::FCF_SEC_BIT];
          st_next.hdr.pend     = st_reg.hdr.fcf[mhp_pkg::FCF_PEND_BIT];
          st_next.hdr.ack_req  = st_reg.hdr.fcf[mhp_pkg::FCF_AR_BIT];
          // [R17] PAN compression flag
          st_next.hdr.pan_comp = st_reg.hdr.fcf[mhp_pkg::FCF_PANC_BIT];
          // [R1] [R2] [R5] modes and version from high octet
          st_next.hdr.dmode = st_next.hdr.fcf[mhp_pkg::FCF_DMODE_LSB +: 2];
          st_next.hdr.ver   = st_next.hdr.fcf[mhp_pkg::FCF_VER_LSB +: 2];
          st_next.hdr.smode = st_next.hdr.fcf[mhp_pkg::FCF_SMODE_LSB +: 2];
        end
        // [R8] sequence number capture
        P_SEQ:  st_next.hdr.seq = d;
        P_DPAN: begin
          st_next.hdr.dpan[bi[3:0] +: 8] = d;
          flen = mhp_pkg::LEN_PAN;
        end
        P_DADR: begin
          st_next.hdr.daddr[bi +: 8] = d;
          flen = addr_len(st_reg.hdr.dmode);
        end
        P_SPAN: begin
          st_next.hdr.span[bi[3:0] +: 8] = d;
          flen = mhp_pkg::LEN_PAN;
        end
        P_SADR: begin
          st_next.hdr.saddr[bi +: 8] = d;
          flen = addr_len(st_reg.hdr.smode);
        end
        P_AUX: begin
          if (st_reg.cnt == '0) begin
            st_next.hdr.aux_len = aux_len_of(d[mhp_pkg::AUX_KM_LSB +: 2]);
          end
          flen = st_next.hdr.aux_len;
        end
        P_FCS: st_next.hdr.fcs[bi[3:0] +: 8] = d;
        default: flen = mhp_pkg::LEN_ONE;
      endcase
      fend = (st_reg.ps != P_BODY) && (st_reg.ps != P_FCS) && (st_reg.cnt == flen - 4'h1);
      nf = next_field(st_reg.ps, present(st_next.hdr));
      if (rem_n == '0) begin
        st_next.ps = P_IDLE;
        st_next.hdr.truncated = st_next.hdr.truncated || (st_reg.ps != P_FCS);
        st_next.hv = 1'b1;
        st_next.dn = 1'b1;
        st_next.frames = st_reg.frames + 16'h0001;
        st_next.vd = judge(st_next.hdr, st_reg.ctrl);
      end else if (rem_n == mhp_pkg::FCS_LEN && st_reg.ps != P_FCS) begin
        // [R14] last two octets go to the footer in frames of three or more octets
        st_next.ps = P_FCS;
        st_next.cnt = '0;
        if (st_reg.ps != P_BODY) begin
          st_next.hdr.body_off = st_reg.hdr.length - mhp_pkg::FCS_LEN;
          st_next.hdr.truncated = !(fend && nf == P_BODY);
        end
      end else if (fend) begin
        // [R9] [R18] walk to the next present field
        st_next.ps = nf;
        st_next.cnt = '0;
        if (nf == P_BODY) begin
          st_next.hdr.body_off = st_reg.hdr.length - rem_n;
        end
      end
    end
    // Bus slave: zero wait states, write lands in the data phase
    ap = hsel && htrans[1] && hready;
    st_next.hwr = ap && hwrite;
    if (ap) begin
      st_next.waddr = haddr[7:0];
    end
    if (st_reg.hwr && st_reg.waddr == mhp_pkg::REG_CTRL) begin
      ctrl_fw = hwdata[3:0];
    end
    st_next.ctrl = ctrl_fw;
    if (ap && !hwrite) begin
      unique case (haddr[7:0])
        mhp_pkg::REG_CTRL:    st_next.hrdata = {28'h0000000, ctrl_fw};
        mhp_pkg::REG_STATUS:  st_next.hrdata = {21'h000000, st_reg.hdr.ver, st_reg.vd.sec_2003,
                                                st_reg.vd.ack_ok, st_reg.vd.filter_pass,
                                                st_reg.hdr.truncated, st_reg.ps, st_reg.hv};
        mhp_pkg::REG_FCF_SEQ: st_next.hrdata = {8'h00, st_reg.hdr.seq, st_reg.hdr.fcf};
        mhp_pkg::REG_FRAMES:  st_next.hrdata = {16'h0000, st_reg.frames};
        default:              st_next.hrdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= TOP_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hdr       = st_reg.hdr;
  assign verdict   = st_reg.vd;
  assign hdr_valid = st_reg.hv;
  assign hreadyout = st_reg.hrdy;
  assign hresp     = st_reg.hresp;
  assign hrdata    = st_reg.hrdata;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_dest_mode: assert property (st_reg.dn |-> hdr.dmode == hdr.fcf[11:10]) // [R1]
    else $error("destination mode not from bits 11:10");
  a_src_mode: assert property (st_reg.dn |-> hdr.smode == hdr.fcf[15:14]) // [R2]
    else $error("source mode not from bits 15:14");
  a_dpan_need: assert property (st_reg.ps == P_DPAN |-> hdr.dmode[1]) // [R4]
    else $error("destination PAN parsed without address mode");
  a_ver_policy: assert property (st_reg.dn && verdict.ack_ok |-> // [R6]
    hdr.ver <= $past(st_reg.ctrl[2:1])) else $error("ack outside version policy");
  a_filter_bits: assert property (st_reg.dn |-> verdict.filter_bits == // [R7]
    ($past(st_reg.ctrl[0]) ? (hdr.fcf & mhp_pkg::FILTER_MASK) : 16'h0000))
    else $error("filter bits wrong");
  a_ack_seq: assert property (st_reg.dn |-> verdict.ack_seq == hdr.seq) // [R8]
    else $error("ack sequence mismatch");
  a_src_pan_gone: assert property (st_reg.dn && hdr.pan_comp && hdr.dmode[1] && // [R10]
    hdr.smode[1] |-> hdr.span == 16'h0000) else $error("compressed source PAN read");
  a_aux_gate: assert property (st_reg.ps == P_AUX |-> hdr.sec) // [R11]
    else $error("security header without enable bit");
  a_sec_class: assert property (verdict.sec_2003 |-> !verdict.sec_2006 && // [R12]
    !verdict.compat) else $error("security classes overlap");
  a_empty_addr: assert property (st_reg.dn && verdict.filter_pass && hdr.dmode == 2'h0 && // [R13]
    hdr.smode == 2'h0 |-> hdr.ftype == 3'h2 || $past(st_reg.ctrl[3]))
    else $error("empty address");
  a_fcs_tail: assert property (pop && !fifo_word.sof && st_reg.rem == 7'h03 && // [R14]
    st_reg.ps inside {[P_FCF0:P_BODY]} |=> st_reg.ps == P_FCS) else $error("footer missed");
  a_type_pass: assert property (verdict.filter_pass |-> hdr.ftype <= 3'h3) // [R16]
    else $error("reserved type passed");
  a_stall_hold: assert property (hdr_valid && !res_ready |=> hdr_valid && $stable(hdr))
    else $error("result dropped while stalled");

  c_acked: cover property (st_reg.dn && verdict.ack_ok);
  c_compressed: cover property (st_reg.dn && hdr.pan_comp && hdr.dmode[1] && hdr.smode[1]);
  c_secured: cover property (st_reg.ps == P_AUX ##1 st_reg.ps == P_BODY);
  c_backpressure: cover property (!in_ready ##1 in_ready);
endmodule

// File: inc/mhp_pkg.sv
// Purpose: Shared constants and carriers for the MAC header parser
// Assumes: One octet stream, PHR first, LSB octet of each multi-octet field first
// Notes:   Register offsets are byte addresses of aligned 32-bit words
package mhp_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int FIFO_W = 9;
  localparam int FIFO_D = 16;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_FCF_SEQ = 8'h08;
  localparam logic [7:0] REG_FRAMES  = 8'h0C;
  localparam int CTRL_AACK_BIT   = 0;
  localparam int CTRL_POL_LSB    = 1;
  localparam int CTRL_NONSTD_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h2;

  // ****************************************
  // Frame control layout and encodings
  // ****************************************
  localparam int FCF_TYPE_LSB  = 0;
  localparam int FCF_SEC_BIT   = 3;
  localparam int FCF_PEND_BIT  = 4;
  localparam int FCF_AR_BIT    = 5;
  localparam int FCF_PANC_BIT  = 6;
  localparam int FCF_DMODE_LSB = 10;
  localparam int FCF_VER_LSB   = 12;
  localparam int FCF_SMODE_LSB = 14;
  localparam logic [15:0] FILTER_MASK = 16'hFC4F;
  localparam logic [1:0] AM_NONE  = 2'h0;
  localparam logic [1:0] AM_RES   = 2'h1;
  localparam logic [1:0] AM_SHORT = 2'h2;
  localparam logic [1:0] AM_EXT   = 2'h3;
  localparam logic [2:0] FT_BEACON = 3'h0;
  localparam logic [2:0] FT_ACK    = 3'h2;
  localparam logic [2:0] FT_CMD    = 3'h3;
  localparam logic [1:0] FV_2003 = 2'h0;
  localparam logic [1:0] FV_2006 = 2'h1;

  // ****************************************
  // Field lengths in octets
  // ****************************************
  localparam logic [3:0] LEN_ONE   = 4'h1;
  localparam logic [3:0] LEN_PAN   = 4'h2;
  localparam logic [3:0] LEN_SHORT = 4'h2;
  localparam logic [3:0] LEN_EXT   = 4'h8;
  localparam logic [6:0] FCS_LEN   = 7'h02;
  localparam int AUX_KM_LSB = 3;
  localparam logic [3:0] AUX_LEN_KM0 = 4'h5;
  localparam logic [3:0] AUX_LEN_KM1 = 4'h6;
  localparam logic [3:0] AUX_LEN_KM2 = 4'hA;
  localparam logic [3:0] AUX_LEN_KM3 = 4'hE;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic        sof;
    logic [7:0]  octet;
  } mhp_word_t;

  typedef struct packed {
    logic [6:0]  length;
    logic [15:0] fcf;
    logic [2:0]  ftype;
    logic        sec;
    logic        pend;
    logic        ack_req;
    logic        pan_comp;
    logic [1:0]  dmode;
    logic [1:0]  ver;
    logic [1:0]  smode;
    logic [7:0]  seq;
    logic [15:0] dpan;
    logic [63:0] daddr;
    logic [15:0] span;
    logic [63:0] saddr;
    logic [3:0]  aux_len;
    logic [6:0]  body_off;
    logic [15:0] fcs;
    logic        truncated;
  } mhp_hdr_t;

  typedef struct packed {
    logic [15:0] filter_bits;
    logic        ver_reserved;
    logic        sec_2003;
    logic        sec_2006;
    logic        compat;
    logic        filter_pass;
    logic        ack_ok;
    logic [7:0]  ack_seq;
  } mhp_verdict_t;

endpackage

// File: dv/mhp_src_model.sv
// Purpose: Baseband octet source feeding the header parser
// Assumes: Caller enters send just after a rising edge
// Notes:   Data line shows the inverse of the last octet between frames
`timescale 1ns/1ps
module mhp_src_model (
  input  wire logic       clk,
  output logic            in_valid,
  output logic            in_sof,
  output logic [7:0]      in_octet,
  input  wire logic       in_ready
);
  initial begin
    in_valid = 1'b0;
    in_sof = 1'b0;
    in_octet = 8'h00;
  end
  // Length, then control octets, footer last
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      in_valid <= 1'b1;
      in_sof <= (i == 0);
      in_octet <= b[i];
      do @(posedge clk); while (in_ready !== 1'b1);
    end
    in_valid <= 1'b0;
    in_sof <= 1'b0;
    in_octet <= ~in_octet;
  endtask
endmodule

// File: dv/mhp_parser_bench.sv
// Purpose: Self-checking bench for the MAC header parser
// Assumes: Results compared in order through expectation queues
// Notes:   Slow consumer keeps the octet FIFO near full
`timescale 1ns/1ps
module mhp_parser_bench;
  logic                  clk = 1'b0, rst = 1'b1, res_ready = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic                  in_valid, in_sof, in_ready, hdr_valid, hreadyout, hresp;
  logic [7:0]            in_octet;
  logic [1:0]            htrans = 2'h0;
  logic [2:0]            hsize = 3'h2;
  logic [31:0]           haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  mhp_pkg::mhp_hdr_t     hdr, eq[$], mq[$];
  mhp_pkg::mhp_verdict_t verdict;
  logic [15:0]           fq[$];
  logic                  exp_pass;
  int                    seed = 32'h161F2E18;
  int                    mismatches = 0, checks = 0;
  always #5 clk = ~clk;

  mhp_src_model u_mhp_src_model (.clk(clk), .in_valid(in_valid), .in_sof(in_sof),
    .in_octet(in_octet), .in_ready(in_ready));
  mhp_parser u_mhp_parser (.clk(clk), .rst(rst), .in_valid(in_valid), .in_sof(in_sof),
    .in_octet(in_octet), .in_ready(in_ready), .hdr(hdr), .verdict(verdict),
    .hdr_valid(hdr_valid), .res_ready(res_ready), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

  task automatic chk(input logic bad, input string msg);
    checks++;
    if (bad !== 1'b0) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk(hresp !== 1'b0, "error response");
  endtask

  task automatic put(inout logic [7:0] q[$], input logic [63:0] v, input int n);
    for (int i = 0; i < n; i++) q.push_back(v[8*i+:8]);
  endtask

  // ****************************************
  // Frame builder with expected header
  // ****************************************
  task automatic frame(input logic [1:0] dm, sm, input logic pc, sec);
    logic [7:0]        b[$];
    logic [63:0]       da, sa, r;
    logic [15:0]       fcf;
    logic              sp;
    mhp_pkg::mhp_hdr_t e, m;
    da = {$random(seed), $random(seed)};
    sa = {$random(seed), $random(seed)};
    r = {$random(seed), $random(seed)};
    // Legacy secured layout differs, so secured frames use the newer version
    fcf = {sm, sec ? 2'h1 : r[47:46], dm, 3'h0, pc, r[48], 1'b0, sec, 3'h1};
    sp = sm[1] && !(pc && dm[1]);
    b = {8'h00, fcf[7:0], fcf[15:8], r[7:0]};
    if (dm[1]) begin
      put(b, r[23:8], 2);
      put(b, da, dm[0] ? 8 : 2);
    end
    if (sp) put(b, r[39:24], 2);
    if (sm[1]) put(b, sa, sm[0] ? 8 : 2);
    if (sec) put(b, {r[31:0], 8'h00}, 5);
    e = '0;
    m = '1;
    e.body_off = 7'(b.size() - 1);
    put(b, sa, 4);
    b[0] = 8'(b.size() - 1);
    m.dpan = {16{dm[1]}};
    m.daddr = dm[1] ? {{48{dm[0]}}, 16'hFFFF} : 64'h0;
    m.span = {16{sp}};
    m.saddr = sm[1] ? {{48{sm[0]}}, 16'hFFFF} : 64'h0;
    e.length = b[0][6:0];
    e.fcf = fcf;
    e.ftype = 3'h1;
    e.sec = sec;
    e.ack_req = r[48];
    e.pan_comp = pc;
    e.dmode = dm;
    e.ver = fcf[13:12];
    e.smode = sm;
    e.seq = r[7:0];
    e.dpan = r[23:8] & m.dpan;
    e.daddr = da & m.daddr;
    e.span = r[39:24] & m.span;
    e.saddr = sa & m.saddr;
    e.aux_len = sec ? 4'h5 : 4'h0;
    e.fcs = sa[31:16];
    eq.push_back(e);
    mq.push_back(m);
    fq.push_back(fcf & mhp_pkg::FILTER_MASK);
    u_mhp_src_model.send(b);
    @(posedge clk);
  endtask

  // ****************************************
  // Result watcher, stalls often to back up the FIFO
  // ****************************************
  always @(posedge clk) begin
    res_ready <= 1'(($random(seed) & 3) == 0);
    if (hdr_valid === 1'b1 && res_ready === 1'b1) begin
      if (eq.size() == 0) chk(1'b1, "result with none expected");
      else begin
        exp_pass = eq[0].dmode != 2'h1 && eq[0].smode != 2'h1 &&
                   (eq[0].dmode | eq[0].smode) != 2'h0;
        chk((hdr & mq[0]) !== eq[0], "header fields");
        chk({verdict.filter_pass, verdict.ack_ok, verdict.compat} !== {exp_pass,
            exp_pass && eq[0].ack_req && !eq[0].ver[1], !eq[0].sec && eq[0].ver == 2'h0}, "ack");
        chk(verdict.ack_seq !== eq[0].seq, "ack sequence");
        chk(verdict.filter_bits !== fq[0], "filter bits");
        chk({verdict.ver_reserved, verdict.sec_2003, verdict.sec_2006} !==
            {eq[0].ver[1], 1'b0, eq[0].sec}, "version class");
        void'(eq.pop_front());
        void'(mq.pop_front());
        void'(fq.pop_front());
      end
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    ahb(1'b0, mhp_pkg::REG_CTRL, 32'h0);
    chk(rd !== {28'h0, mhp_pkg::CTRL_RESET}, "control reset value");
    ahb(1'b1, mhp_pkg::REG_CTRL, 32'h3);
    ahb(1'b0, mhp_pkg::REG_CTRL, 32'h0);
    chk(rd !== 32'h3, "control readback");
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd !== 32'h0, "unmapped read");
    // Every mode pair, compression on and off
    for (int k = 0; k < 32; k++) frame(k[3:2], k[1:0], k[4], k[4] & k[0]);
    for (int t = 0; t < 3000 && eq.size() > 0; t++) @(posedge clk);
    chk(eq.size() != 0, "results missing");
    ahb(1'b0, mhp_pkg::REG_FRAMES, 32'h0);
    chk(rd[15:0] !== 16'h0020, "frame count");
    conclude();
  end

  initial begin
    #400000;
    mismatches++;
    conclude();
  end
endmodule
